// ---- verilog/emp_pkg.sv ----
// constants and types shared by the external memory pin block
package emp_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SDRAM_BASE = 8'h04;
  localparam logic [7:0] REG_IO_BASE0 = 8'h08;
  localparam logic [7:0] REG_IO_BASE1 = 8'h0C;
  localparam logic [7:0] REG_IO_BASE2 = 8'h10;
  localparam logic [7:0] REG_STATIC_MAP0 = 8'h14;
  localparam logic [7:0] REG_STATIC_MAP1 = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1C;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_LED0_LSB = 0;
  localparam int CTRL_LED1_LSB = 4;
  localparam int CTRL_ACC_LSB = 8;
  localparam int MAP_MASK_LSB = 8;
  localparam int STAT_WDOG_POL = 0;
  localparam int STAT_BOOT_LSB = 1;
  localparam int STAT_VALID = 3;
  localparam int STAT_BUSY = 4;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_RST = 12'h0300;
  localparam logic [2:0] SDRAM_BASE_RST = 3'h0;
  localparam logic [11:0] IO_BASE_RST = 12'hFFF;
  localparam logic [13:0] STATIC_MAP_RST = 14'h0000;
  localparam logic [3:0] SYNC_RST = 4'h1;

  // ----------------------------------------------------------------
  // counts of cycles
  // ----------------------------------------------------------------
  localparam logic [1:0] STRAP_SETTLE_CYC = 2'h3;

  // ----------------------------------------------------------------
  // led function codes and boot width codes
  // ----------------------------------------------------------------
  localparam logic [2:0] LED_SPEED = 3'h0;
  localparam logic [2:0] LED_LINK = 3'h1;
  localparam logic [2:0] LED_DUPLEX = 3'h2;
  localparam logic [2:0] LED_COLLISION = 3'h3;
  localparam logic [2:0] LED_ACTIVITY = 3'h4;
  localparam logic [2:0] LED_FDX_COLLISION = 3'h5;
  localparam logic [2:0] LED_LINK_ACT = 3'h6;
  localparam logic [1:0] BOOT_RESERVED = 2'h0;
  localparam logic [1:0] BOOT_BYTE = 2'h1;
  localparam logic [1:0] BOOT_HALF = 2'h2;
  localparam logic [1:0] BOOT_WORD = 2'h3;

  // ----------------------------------------------------------------
  // access sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SD_ACT,
    ST_SD_CMD,
    ST_STATIC
  } emp_state_t;

endpackage

// ---- verilog/emp_led_select.sv ----
// wan indicator function selector
`timescale 1ns/1ps
`default_nettype none
module emp_led_select (
  input wire logic [2:0] func_i,
  input wire logic speed_i,
  input wire logic link_i,
  input wire logic duplex_i,
  input wire logic collision_i,
  input wire logic activity_i,
  output logic on_o
);

  // pick the status that lights the indicator
  always_comb
  begin
    case (func_i)
      emp_pkg::LED_SPEED: on_o = speed_i;
      emp_pkg::LED_LINK: on_o = link_i;
      emp_pkg::LED_DUPLEX: on_o = duplex_i;
      emp_pkg::LED_COLLISION: on_o = collision_i;
      emp_pkg::LED_ACTIVITY: on_o = activity_i;
      emp_pkg::LED_FDX_COLLISION: on_o = duplex_i & collision_i;
      emp_pkg::LED_LINK_ACT: on_o = link_i & ~activity_i; // blinks off
      default: on_o = 1'b0;
    endcase
  end

endmodule // emp_led_select
`default_nettype wire

// ---- verilog/emp_mem_pins.sv ----
// external memory pin sequencer with reset straps and wan indicators
//
// Contract
// - one low select per sdram bank, two banks
// - separate low row, column, write strobes to sdram
// - high mask blocks write byte, disables read
// - mask bits 0..3 cover lanes low to high
// - three io selects, 16KB, low only when addressed
// - low wait input stretches the access
// - two static selects from programmable address mapping
// - shared low output enable during static reads
// - output enable pin strap sets watchdog polarity
// - four low byte writes, never for sdram
// - indicator 0 follows control bits 2 to 0
// - indicator 1 follows control bits 6 to 4
// - function codes speed through link activity
// - indicator pin straps set boot width
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module emp_mem_pins (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [25:0] req_addr_i,
  input wire logic [3:0] req_be_i,
  output logic req_ready_o,
  output logic req_done_o,
  output logic req_err_o,
  output logic [1:0] sdram_bank_select_n_o,
  output logic row_strobe_n_o,
  output logic column_strobe_n_o,
  output logic sdram_write_n_o,
  output logic [3:0] sdram_byte_mask_o,
  output logic [2:0] io_bank_select_n_o,
  input wire logic extend_access_n_i,
  output logic [1:0] boot_mem_bank_select_n_o,
  output logic static_output_enable_n_o,
  output logic static_output_enable_n_oe_o,
  input wire logic watchdog_polarity_strap_i,
  output logic [3:0] static_byte_write_n_o,
  output logic [1:0] wan_indicator_o,
  output logic [1:0] wan_indicator_oe_o,
  input wire logic [1:0] boot_width_strap_i,
  input wire logic phy_speed_i,
  input wire logic phy_link_i,
  input wire logic phy_duplex_i,
  input wire logic phy_collision_i,
  input wire logic phy_activity_i,
  output logic watchdog_active_high_o,
  output logic [1:0] boot_width_o,
  output logic strap_valid_o
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  emp_pkg::emp_state_t state_q;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [1:0] strap_cnt_q;
  logic strap_valid_q;
  logic wdog_pol_q;
  logic [1:0] boot_width_q;
  logic [11:0] ctrl_q;
  logic [2:0] sd_base_q;
  logic [11:0] io_base_q [3];
  logic [13:0] st_map_q [2];
  logic [31:0] rdata_q;
  logic [3:0] acc_cnt_q;
  logic wr_q;
  logic [3:0] be_q;
  logic [1:0] sd_cs_q;
  logic [2:0] io_sel_q;
  logic [1:0] st_sel_q;
  logic done_q;
  logic err_q;
  logic [1:0] led_on;
  logic [1:0] led_q;
  logic [2:0] io_hit;
  logic [1:0] st_hit;
  logic sd_hit;
  logic wait_n;
  logic sd_phase;
  logic acc_phase;
  logic accept;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // a static bank matches where unmasked upper address bits equal its base
  function automatic logic static_match(input logic [25:0] addr,
                                        input logic [13:0] map);
    static_match = ((addr[25:20] ^ map[5:0])
                    & ~map[emp_pkg::MAP_MASK_LSB +: 6]) == 6'h00;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers: bit 0 wait, bit 1 polarity, bits 3:2 width
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sync1_q <= emp_pkg::SYNC_RST;
      sync2_q <= emp_pkg::SYNC_RST;
    end
    else
    begin
      sync1_q <= {boot_width_strap_i, watchdog_polarity_strap_i,
                  extend_access_n_i};
      sync2_q <= sync1_q;
    end
  end
  assign wait_n = sync2_q[0];

  // ----------------------------------------------------------------
  // strap capture after reset release
  // ----------------------------------------------------------------
  // pins stay undriven until the synchronisers hold settled strap levels
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      strap_cnt_q <= 2'h0;
      strap_valid_q <= 1'b0;
      wdog_pol_q <= 1'b0;
      boot_width_q <= emp_pkg::BOOT_RESERVED;
    end
    else if (!strap_valid_q)
    begin
      if (strap_cnt_q == emp_pkg::STRAP_SETTLE_CYC)
      begin
        strap_valid_q <= 1'b1;
        wdog_pol_q <= sync2_q[1];
        boot_width_q <= sync2_q[3:2];
      end
      else
      begin
        strap_cnt_q <= strap_cnt_q + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ctrl_q <= emp_pkg::CTRL_RST;
      sd_base_q <= emp_pkg::SDRAM_BASE_RST;
      io_base_q[0] <= emp_pkg::IO_BASE_RST;
      io_base_q[1] <= emp_pkg::IO_BASE_RST;
      io_base_q[2] <= emp_pkg::IO_BASE_RST;
      st_map_q[0] <= emp_pkg::STATIC_MAP_RST;
      st_map_q[1] <= emp_pkg::STATIC_MAP_RST;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == emp_pkg::REG_CTRL)
        ctrl_q <= reg_wdata_i[11:0];
      else if (reg_addr_i == emp_pkg::REG_SDRAM_BASE)
        sd_base_q <= reg_wdata_i[2:0];
      else if (reg_addr_i == emp_pkg::REG_IO_BASE0)
        io_base_q[0] <= reg_wdata_i[11:0];
      else if (reg_addr_i == emp_pkg::REG_IO_BASE1)
        io_base_q[1] <= reg_wdata_i[11:0];
      else if (reg_addr_i == emp_pkg::REG_IO_BASE2)
        io_base_q[2] <= reg_wdata_i[11:0];
      else if (reg_addr_i == emp_pkg::REG_STATIC_MAP0)
        st_map_q[0] <= reg_wdata_i[13:0];
      else if (reg_addr_i == emp_pkg::REG_STATIC_MAP1)
        st_map_q[1] <= reg_wdata_i[13:0];
    end
  end

  // ----------------------------------------------------------------
  // register reads, data in the following cycle
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rdata_q <= 32'h0000_0000;
    else if (!reg_rd_i)
      rdata_q <= 32'h0000_0000;
    else if (reg_addr_i == emp_pkg::REG_CTRL)
      rdata_q <= {20'h0_0000, ctrl_q};
    else if (reg_addr_i == emp_pkg::REG_SDRAM_BASE)
      rdata_q <= {29'h0000_0000, sd_base_q};
    else if (reg_addr_i == emp_pkg::REG_IO_BASE0)
      rdata_q <= {20'h0_0000, io_base_q[0]};
    else if (reg_addr_i == emp_pkg::REG_IO_BASE1)
      rdata_q <= {20'h0_0000, io_base_q[1]};
    else if (reg_addr_i == emp_pkg::REG_IO_BASE2)
      rdata_q <= {20'h0_0000, io_base_q[2]};
    else if (reg_addr_i == emp_pkg::REG_STATIC_MAP0)
      rdata_q <= {18'h0_0000, st_map_q[0]};
    else if (reg_addr_i == emp_pkg::REG_STATIC_MAP1)
      rdata_q <= {18'h0_0000, st_map_q[1]};
    else if (reg_addr_i == emp_pkg::REG_STATUS)
      rdata_q <= {27'h000_0000, state_q != emp_pkg::ST_IDLE,
                  strap_valid_q, boot_width_q, wdog_pol_q};
    else
      rdata_q <= 32'h0000_0000; // unmapped reads zero
  end
  assign reg_rdata_o = rdata_q;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  assign sd_hit = req_addr_i[25:23] == sd_base_q;
  // each io bank spans one 16KB window at its base
  generate
    for (genvar gi = 0; gi < 3; gi++)
    begin : g_io_hit
      assign io_hit[gi] = req_addr_i[25:14] == io_base_q[gi];
    end
    for (genvar gs = 0; gs < 2; gs++)
    begin : g_st_hit
      assign st_hit[gs] = static_match(req_addr_i, st_map_q[gs]);
    end
  endgenerate
  assign req_ready_o = (state_q == emp_pkg::ST_IDLE) && strap_valid_q;
  assign accept = req_valid_i && req_ready_o;

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  // sdram beats above io, io above static; lowest-numbered bank wins
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_q <= emp_pkg::ST_IDLE;
      acc_cnt_q <= 4'h0;
      wr_q <= 1'b0;
      be_q <= 4'h0;
      sd_cs_q <= 2'h0;
      io_sel_q <= 3'h0;
      st_sel_q <= 2'h0;
      done_q <= 1'b0;
      err_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      err_q <= 1'b0;
      case (state_q)
        emp_pkg::ST_IDLE:
        begin
          if (accept)
          begin
            wr_q <= req_write_i;
            be_q <= req_be_i;
            acc_cnt_q <= ctrl_q[emp_pkg::CTRL_ACC_LSB +: 4];
            sd_cs_q <= 2'h0;
            io_sel_q <= 3'h0;
            st_sel_q <= 2'h0;
            if (sd_hit)
            begin
              sd_cs_q <= req_addr_i[22] ? 2'h2 : 2'h1;
              state_q <= emp_pkg::ST_SD_ACT;
            end
            else if (io_hit != 3'h0)
            begin
              io_sel_q <= io_hit[0] ? 3'h1 : (io_hit[1] ? 3'h2 : 3'h4);
              state_q <= emp_pkg::ST_STATIC;
            end
            else if (st_hit != 2'h0)
            begin
              st_sel_q <= st_hit[0] ? 2'h1 : 2'h2;
              state_q <= emp_pkg::ST_STATIC;
            end
            else
            begin
              err_q <= 1'b1; // nothing decodes this address
            end
          end
        end
        emp_pkg::ST_SD_ACT:
          state_q <= emp_pkg::ST_SD_CMD;
        emp_pkg::ST_SD_CMD:
        begin
          done_q <= 1'b1;
          state_q <= emp_pkg::ST_IDLE;
        end
        default:
        begin
          if (acc_cnt_q != 4'h0)
            acc_cnt_q <= acc_cnt_q - 4'h1;
          else if (wait_n) // low wait holds the access
          begin
            done_q <= 1'b1;
            state_q <= emp_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end
  assign req_done_o = done_q;
  assign req_err_o = err_q;

  // ----------------------------------------------------------------
  // memory pins
  // ----------------------------------------------------------------
  assign sd_phase = (state_q == emp_pkg::ST_SD_ACT)
                    || (state_q == emp_pkg::ST_SD_CMD);
  assign acc_phase = state_q == emp_pkg::ST_STATIC;
  assign sdram_bank_select_n_o = ~(sd_cs_q & {2{sd_phase}});
  assign row_strobe_n_o = state_q != emp_pkg::ST_SD_ACT;
  assign column_strobe_n_o = state_q != emp_pkg::ST_SD_CMD;
  assign sdram_write_n_o = !((state_q == emp_pkg::ST_SD_CMD) && wr_q);
  // mask bit i is lane i; masked lanes are off in both directions
  assign sdram_byte_mask_o = sd_phase ? ~be_q : 4'hF;
  assign io_bank_select_n_o = ~(io_sel_q & {3{acc_phase}});
  assign boot_mem_bank_select_n_o = ~(st_sel_q & {2{acc_phase}});
  assign static_output_enable_n_o = !(acc_phase && !wr_q);
  assign static_output_enable_n_oe_o = strap_valid_q;
  assign static_byte_write_n_o = ~(be_q & {4{acc_phase && wr_q}});

  // ----------------------------------------------------------------
  // wan indicators, driven low to light
  // ----------------------------------------------------------------
  generate
    for (genvar gl = 0; gl < 2; gl++)
    begin : g_led
      emp_led_select u_led (
        .func_i(ctrl_q[gl * 4 +: 3]),
        .speed_i(phy_speed_i),
        .link_i(phy_link_i),
        .duplex_i(phy_duplex_i),
        .collision_i(phy_collision_i),
        .activity_i(phy_activity_i),
        .on_o(led_on[gl])
      );
    end
  endgenerate

  // register the indicator levels
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      led_q <= 2'h3;
    else
      led_q <= ~led_on;
  end
  assign wan_indicator_o = led_q;
  assign wan_indicator_oe_o = {2{strap_valid_q}};
  assign watchdog_active_high_o = wdog_pol_q;
  assign boot_width_o = boot_width_q;
  assign strap_valid_o = strap_valid_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_sd_act;
    !row_strobe_n_o && column_strobe_n_o && sdram_write_n_o;
  endsequence
  sequence s_sd_cmd;
    row_strobe_n_o && !column_strobe_n_o;
  endsequence

  // a row or column strobe needs exactly one bank select low
  property p_sd_one_bank;
    !row_strobe_n_o || !column_strobe_n_o
    |-> $onehot(~sdram_bank_select_n_o);
  endproperty
  a_sd_one_bank: assert property (p_sd_one_bank)
    else $error("sdram strobe without exactly one bank select");

  property p_sd_seq;
    accept && sd_hit |=> s_sd_act ##1 s_sd_cmd ##1 req_done_o;
  endproperty
  a_sd_seq: assert property (p_sd_seq)
    else $error("sdram row then column sequence broken");

  property p_mask_lanes;
    accept && sd_hit |=> ##1 sdram_byte_mask_o == ~$past(req_be_i, 2);
  endproperty
  a_mask_lanes: assert property (p_mask_lanes)
    else $error("byte mask does not match requested lanes");

  property p_io_addressed;
    io_bank_select_n_o != 3'h7
    |-> $onehot(~io_bank_select_n_o) && !req_ready_o;
  endproperty
  a_io_addressed: assert property (p_io_addressed)
    else $error("io select outside an access");

  property p_wait_stretch;
    acc_phase && acc_cnt_q == 4'h0 && !wait_n |=> acc_phase && !req_done_o;
  endproperty
  a_wait_stretch: assert property (p_wait_stretch)
    else $error("access ended while wait was asserted");

  property p_oe_read;
    !static_output_enable_n_o
    |-> !wr_q && (io_bank_select_n_o != 3'h7
                  || boot_mem_bank_select_n_o != 2'h3);
  endproperty
  a_oe_read: assert property (p_oe_read)
    else $error("output enable without a static read");

  property p_no_write_sdram;
    static_byte_write_n_o != 4'hF |-> sdram_bank_select_n_o == 2'h3;
  endproperty
  a_no_write_sdram: assert property (p_no_write_sdram)
    else $error("byte write asserted during sdram access");

  property p_led0_link;
    strap_valid_q && ctrl_q[2:0] == emp_pkg::LED_LINK
    |=> wan_indicator_o[0] == !$past(phy_link_i);
  endproperty
  a_led0_link: assert property (p_led0_link)
    else $error("indicator 0 does not follow link");

  property p_strap_latch;
    $rose(strap_valid_q)
    |-> watchdog_active_high_o == $past(sync2_q[1])
        && boot_width_o == $past(sync2_q[3:2]);
  endproperty
  a_strap_latch: assert property (p_strap_latch)
    else $error("strap values not latched at capture");

  property p_pins_released;
    !strap_valid_q |-> !static_output_enable_n_oe_o
                       && wan_indicator_oe_o == 2'h0;
  endproperty
  a_pins_released: assert property (p_pins_released)
    else $error("shared pins driven before straps captured");

endmodule // emp_mem_pins
`default_nettype wire

// ---- dv/emp_mem_model.sv ----
// far-side model: board strap resistors and a slow static device
`timescale 1ns/1ps
`default_nettype none
module emp_mem_model (
  input wire logic clk_i,
  input wire logic [2:0] io_sel_n_i,
  input wire logic [1:0] boot_sel_n_i,
  input wire logic oe_n_i,
  input wire logic oe_en_i,
  input wire logic [1:0] led_i,
  input wire logic [1:0] led_en_i,
  input wire logic pol_i,
  input wire logic [1:0] width_i,
  input wire logic [3:0] wait_len_i,
  output logic wait_n_o,
  output logic pol_pin_o,
  output logic [1:0] width_pin_o
);
  logic [3:0] cnt_q;
  logic sel;

  // strap resistors set the level only while the device lets go
  assign pol_pin_o = oe_en_i ? oe_n_i : pol_i;
  assign width_pin_o = (led_en_i & led_i) | (~led_en_i & width_i);

  // count cycles of the current select
  assign sel = ~&{io_sel_n_i, boot_sel_n_i};
  always_ff @(posedge clk_i)
  begin
    if (!sel)
      cnt_q <= 4'h0;
    else if (cnt_q != 4'hF)
      cnt_q <= cnt_q + 4'h1;
  end

  // slow device pulls wait low early in its access; pull-up otherwise
  assign wait_n_o = ~(sel && cnt_q < wait_len_i);
endmodule // emp_mem_model
`default_nettype wire

// ---- dv/tb.sv ----
// self-checking bench for the external memory pin block
`timescale 1ns/1ps
`default_nettype none
module tb;
  // --------
  // signals and instances
  // --------
  logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
  logic rv = 1'b0, rw = 1'b0, pol = 1'b0;
  logic row, col, sw, rdy, done, err, oe, oe_en, polp, wah, sv, wait_n;
  logic [7:0] raddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [25:0] ra = 26'h000_0000;
  logic [3:0] rbe = 4'h0, wlen = 4'h0, msk, bw;
  logic [4:0] phy = 5'h00;
  logic [1:0] wid = 2'h0, sds, bs, led, led_en, wp, bwid;
  logic [2:0] ios;
  logic [19:0] snap [0:15];
  int n_mismatch = 0, total_checks = 0, cyc = 0, lat;

  emp_mem_pins dut (.sys_clk_i(clk), .resetn_i(rstn), .reg_addr_i(raddr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .req_valid_i(rv), .req_write_i(rw), .req_addr_i(ra), .req_be_i(rbe),
    .req_ready_o(rdy), .req_done_o(done), .req_err_o(err),
    .sdram_bank_select_n_o(sds), .row_strobe_n_o(row),
    .column_strobe_n_o(col), .sdram_write_n_o(sw),
    .sdram_byte_mask_o(msk), .io_bank_select_n_o(ios),
    .extend_access_n_i(wait_n), .boot_mem_bank_select_n_o(bs),
    .static_output_enable_n_o(oe), .static_output_enable_n_oe_o(oe_en),
    .watchdog_polarity_strap_i(polp), .static_byte_write_n_o(bw),
    .wan_indicator_o(led), .wan_indicator_oe_o(led_en),
    .boot_width_strap_i(wp), .phy_speed_i(phy[4]), .phy_link_i(phy[3]),
    .phy_duplex_i(phy[2]), .phy_collision_i(phy[1]),
    .phy_activity_i(phy[0]), .watchdog_active_high_o(wah),
    .boot_width_o(bwid), .strap_valid_o(sv));

  emp_mem_model far (.clk_i(clk), .io_sel_n_i(ios), .boot_sel_n_i(bs),
    .oe_n_i(oe), .oe_en_i(oe_en), .led_i(led), .led_en_i(led_en),
    .pol_i(pol), .width_i(wid), .wait_len_i(wlen), .wait_n_o(wait_n),
    .pol_pin_o(polp), .width_pin_o(wp));

  always #2.5 clk = ~clk;

  // cut a hung run short
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      report_and_stop;
    end
  end

  // --------
  // shared tasks
  // --------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    raddr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    raddr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, e);
  endtask

  // one access; snap holds the pins in each cycle after the take
  task automatic acc(input logic w, input logic [25:0] a,
                     input logic [3:0] b);
    @(posedge clk);
    rv <= 1'b1;
    rw <= w;
    ra <= a;
    rbe <= b;
    #1;
    while (rdy !== 1'b1)
      @(posedge clk) #1;
    lat = 0;
    // the next edge takes the request; snap[k] is cycle k after it
    do
    begin
      @(posedge clk);
      rv <= 1'b0;
      #1 lat++;
      snap[lat] = {err, sds, row, col, sw, msk, ios, bs, oe, bw};
    end while (done !== 1'b1 && err !== 1'b1 && lat < 15);
  endtask

  // indicator level for a function code and {speed,link,dup,coll,act}
  function automatic logic lit(input logic [2:0] f, input logic [4:0] p);
    logic [7:0] t;
    t = {1'b0, p[3] & ~p[0], p[2] & p[1], p[0], p[1], p[2], p[3], p[4]};
    return t[f];
  endfunction

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // --------
  // scenarios
  // --------
  task automatic boot(input logic p, input logic [1:0] w);
    rstn <= 1'b0;
    pol <= p;
    wid <= w;
    repeat (12) @(posedge clk);
    check({sv, led_en, oe_en, ios, sds}, 9'h01F);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check(sv, 1'b0);
    @(posedge clk);
    #1 check({sv, wah, bwid}, {1'b1, p, w});
    check(led_en, 2'h3);
    rchk(emp_pkg::REG_STATUS, {27'h000_0000, 2'h1, w, p});
    rchk(emp_pkg::REG_CTRL, 32'h0000_0300);
    rchk(emp_pkg::REG_IO_BASE2, 32'h0000_0FFF);
    rchk(8'h20, 32'h0000_0000);
    $display("done: straps %b %b", p, w);
  endtask

  task automatic t_led;
    logic [4:0] pat [0:2];
    logic [2:0] g;
    pat = '{5'h16, 5'h09, 5'h08};
    for (int k = 0; k < 3; k++)
      for (int f = 0; f < 8; f++)
      begin
        g = 3'(7 - f);
        @(posedge clk);
        phy <= pat[k];
        wreg(emp_pkg::REG_CTRL, {20'h0_0000, 4'h3, 1'b0, g, 1'b0, 3'(f)});
        repeat (3) @(posedge clk);
        #1 check(led, {~lit(g, pat[k]), ~lit(3'(f), pat[k])});
      end
    rchk(emp_pkg::REG_CTRL, 32'h0000_0307);
    $display("done: indicators");
  endtask

  task automatic t_sdram;
    acc(1'b1, 26'h040_0000, 4'h6);
    check(snap[1], 20'h2_E7FF);
    check(snap[2], 20'h3_27FF);
    check(snap[3], 20'h7_FFFF);
    check(lat, 3);
    acc(1'b0, 26'h000_0010, 4'hF);
    check(snap[1], 20'h4_C3FF);
    check(snap[2], 20'h5_43FF);
    $display("done: sdram");
  endtask

  task automatic t_io;
    wreg(emp_pkg::REG_IO_BASE1, 32'h0000_0400);
    acc(1'b0, 26'h100_3FFC, 4'hF);
    check(snap[1], 20'h7_FEEF);
    check(snap[4], 20'h7_FEEF);
    check(snap[5], 20'h7_FFFF);
    check(lat, 5);
    wlen <= 4'h6;
    acc(1'b0, 26'h100_3FFC, 4'hF);
    check(lat > 5 && lat < 15, 1'b1);
    wlen <= 4'h0;
    acc(1'b0, 26'h100_4000, 4'hF);
    check(snap[1], 20'hF_FFFF);
    check(lat, 1);
    $display("done: io banks");
  endtask

  task automatic t_static;
    wreg(emp_pkg::REG_STATIC_MAP1, 32'h0000_0011);
    wreg(emp_pkg::REG_CTRL, 32'h0000_0100);
    acc(1'b1, 26'h110_0000, 4'h5);
    check(snap[1], 20'h7_FFBA);
    check(lat, 3);
    rchk(emp_pkg::REG_STATIC_MAP1, 32'h0000_0011);
    wreg(emp_pkg::REG_SDRAM_BASE, 32'h0000_0007);
    rchk(emp_pkg::REG_SDRAM_BASE, 32'h0000_0007);
    acc(1'b0, 26'h380_0000, 4'hF);
    check(snap[1], 20'h4_C3FF);
    $display("done: static bank");
  endtask

  // main sequence, with three more resets after traffic
  initial
  begin
    boot(1'b0, emp_pkg::BOOT_BYTE);
    t_led;
    t_sdram;
    t_io;
    t_static;
    boot(1'b1, emp_pkg::BOOT_HALF);
    boot(1'b1, emp_pkg::BOOT_WORD);
    boot(1'b0, emp_pkg::BOOT_RESERVED);
    report_and_stop;
  end
endmodule // tb
`default_nettype wire
